// ==== mcg_ctrl.v ====
// machine-check global control: capability, status, enable, legacy log
//
// Summary of operation
// - detected hardware error raises abort-class exception
// - no restart promised; error info kept readable
// - banks tied to units; model register access
// - capability low byte gives bank count
// - capability bit 8 flags enable register
// - capability bit 9 flags extended registers
// - bit 11 makes bank bits 56:53 architectural
// - capability bits 23:16 count extended registers
// - capability is read-only; writes undefined
// - status bit 0 says restart is reliable
// - status bit 1 ties pointer to error
// - exception sets bit 2; software may change
// - second event during check means shutdown
// - read-cycle data parity error is reportable
// - failed bus cycle is reportable
// - legacy log written before exception raised
// - enable all ones on, all zeros off
//
// how the block behaves, in short:
// - software reaches every register through one access port;
//   a read or write request lasts one cycle and is answered
//   exactly one cycle later by valid, fault and read data
// - the capability word is a constant; writes to it are
//   accepted without a fault and have no effect
// - the status word holds three flags; all higher bits are
//   reserved, read back as zero and ignore written values
// - the enable register stores whatever is written, but only
//   the all-ones pattern turns error reporting on
// - after reset the enable register is zero, so every error
//   input is ignored until software enables reporting
// - a legacy error is logged in the cycle after it is seen,
//   and the exception follows one cycle after the log
// - a unit error carries its restart and pointer hints; they
//   are held until the raise cycle and land with the flag
// - a second error while the in-progress flag is set, or an
//   error in the raise cycle itself, ends in shutdown
// - shutdown is sticky; only reset leaves it
//
// hazards and limits a user must know:
// - a software status write in the raise cycle loses to the
//   hardware set, so the flag can never be cleared too early
// - error inputs are taken from logic on the same clock and
//   are not synchronised here
// - error pulses longer than one cycle look like nested checks
//   and will shut the core down
// - the extended state registers are absent in this build
`timescale 1ns/1ps
`default_nettype none
`include "mcg_defs.vh"

module mcg_ctrl (
    input  wire        clk,
    input  wire        reset,
    // register access from the core
    input  wire        msr_rd_en,
    input  wire        msr_wr_en,
    input  wire [31:0] msr_addr,
    input  wire [63:0] msr_wdata,
    output reg  [63:0] msr_rdata,
    output reg         msr_rd_valid,
    output reg         msr_fault,
    // error reports from the hardware units
    input  wire        unit_err,
    input  wire        unit_err_restart_ok,
    input  wire        unit_err_ip_assoc,
    input  wire        read_parity_err,
    input  wire        bus_cycle_fail,
    input  wire [63:0] err_address,
    // exception and shutdown toward the core
    output reg         hardware_error_exception,
    output reg         shutdown
);

    // register selector codes
    // one code per mapped register; none means fault
    localparam [2:0] SEL_NONE   = 3'h0;
    localparam [2:0] SEL_CAP    = 3'h1;
    localparam [2:0] SEL_STATUS = 3'h2;
    localparam [2:0] SEL_CTL    = 3'h3;
    localparam [2:0] SEL_LTYPE  = 3'h4;
    localparam [2:0] SEL_LADDR  = 3'h5;

    // raise sequence states
    // idle: waiting for an enabled error
    // raise: log written, exception or shutdown decided
    // dead: shutdown, left only by reset
    localparam [1:0] ST_IDLE  = 2'h0;
    localparam [1:0] ST_RAISE = 2'h1;
    localparam [1:0] ST_DEAD  = 2'h2;

    // address decode, shared by read and write
    // the enable register decodes only when present, so an
    // absent register faults like any unmapped address
    function [2:0] mcg_sel;
        input [31:0] a;
        begin
            case (a)
                `MCG_ADDR_CAP:    mcg_sel = SEL_CAP;
                `MCG_ADDR_STATUS: mcg_sel = SEL_STATUS;
                `MCG_ADDR_CTL:    mcg_sel = `MCG_CTL_PRESENT ?
                                            SEL_CTL : SEL_NONE;
                `MCG_ADDR_LTYPE:  mcg_sel = SEL_LTYPE;
                `MCG_ADDR_LADDR:  mcg_sel = SEL_LADDR;
                default:          mcg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // capability word, constant
    // field order from high to low: zero pad, extended count,
    // reserved, threshold flag, reserved, extended flag,
    // enable flag, bank count
    wire [63:0] cap_word;               // read-only contents
    assign cap_word = {40'h00_0000_0000,
                       `MCG_EXT_COUNT,
                       4'h0,
                       `MCG_TES_PRESENT,
                       1'b0,
                       `MCG_EXT_PRESENT,
                       `MCG_CTL_PRESENT,
                       `MCG_BANK_COUNT};

    // stored state
    reg  [63:0] ctl_q;        // global enable register
    reg  [63:0] ctl_d;
    reg         restart_pointer_valid_q;       // restart_pointer_valid
    reg         restart_pointer_valid_d;
    reg         error_pointer_valid_q;       // error_pointer_valid
    reg         error_pointer_valid_d;
    reg         check_in_progress_q;       // check_in_progress
    reg         check_in_progress_d;
    reg  [63:0] ltype_q;      // legacy_error_type
    reg  [63:0] ltype_d;
    reg  [63:0] laddr_q;      // legacy_error_address
    reg  [63:0] laddr_d;
    reg  [1:0]  state_q;      // raise sequence
    reg  [1:0]  state_d;
    reg         p_restart_pointer_valid_q;     // restart info held for raise
    reg         p_restart_pointer_valid_d;
    reg         p_error_pointer_valid_q;     // pointer info held for raise
    reg         p_error_pointer_valid_d;

    // decoded access
    wire [2:0]  rd_sel;       // read target
    wire [2:0]  wr_sel;       // write target
    wire        wr_status;    // software writes status
    wire        checks_on;    // machine checks enabled
    wire        legacy_err;   // legacy-class error seen
    wire        event_seen;   // any enabled error this cycle

    assign rd_sel    = mcg_sel(msr_addr);
    assign wr_sel    = mcg_sel(msr_addr);
    assign wr_status = msr_wr_en && (wr_sel == SEL_STATUS);

    // only the all-ones pattern enables; others leave it off
    assign checks_on = (ctl_q == `MCG_ENABLE_ALL);

    // legacy sources both count as machine checks
    assign legacy_err = read_parity_err
                      | bus_cycle_fail;

    assign event_seen = checks_on && (unit_err || legacy_err);

    // next-state logic for registers and raise sequence
    // defaults hold every register; later assignments win,
    // which puts the hardware set after the software write
    always @* begin
        ctl_d    = ctl_q;
        restart_pointer_valid_d   = restart_pointer_valid_q;
        error_pointer_valid_d   = error_pointer_valid_q;
        check_in_progress_d   = check_in_progress_q;
        ltype_d  = ltype_q;
        laddr_d  = laddr_q;
        state_d  = state_q;
        p_restart_pointer_valid_d = p_restart_pointer_valid_q;
        p_error_pointer_valid_d = p_error_pointer_valid_q;

        // enable register takes any written value
        if (msr_wr_en && (wr_sel == SEL_CTL)) begin
            ctl_d = msr_wdata;
        end

        // software may set or clear the status bits
        if (wr_status) begin
            restart_pointer_valid_d = msr_wdata[`MCG_ST_RESTART_POINTER_VALID_BIT];
            error_pointer_valid_d = msr_wdata[`MCG_ST_ERROR_POINTER_VALID_BIT];
            check_in_progress_d = msr_wdata[`MCG_ST_CHECK_IN_PROGRESS_BIT];
        end

        case (state_q)
            // waiting for an error
            ST_IDLE: begin
                if (event_seen) begin
                    // log first, exception next cycle
                    if (legacy_err) begin
                        ltype_d = 64'h0;
                        ltype_d[`MCG_LT_PARITY_BIT] =
                            read_parity_err;
                        ltype_d[`MCG_LT_BUS_BIT] =
                            bus_cycle_fail;
                        laddr_d = err_address;
                    end
                    p_restart_pointer_valid_d = unit_err ? unit_err_restart_ok
                                        : 1'b0;
                    p_error_pointer_valid_d = unit_err ? unit_err_ip_assoc
                                        : 1'b0;
                    state_d  = ST_RAISE;
                end
            end
            // raise, or shut down on a nested check
            ST_RAISE: begin
                if (check_in_progress_q || event_seen) begin
                    state_d = ST_DEAD;
                end else begin
                    // hardware set wins over software write
                    check_in_progress_d  = 1'b1;
                    restart_pointer_valid_d  = p_restart_pointer_valid_q;
                    error_pointer_valid_d  = p_error_pointer_valid_q;
                    state_d = ST_IDLE;
                end
            end
            // shutdown holds until reset
            ST_DEAD: begin
                state_d = ST_DEAD;
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // register state
    // synchronous reset to constants only; no register keeps
    // a value across reset
    always @(posedge clk) begin
        if (reset) begin
            ctl_q    <= `MCG_CTL_RESET;
            restart_pointer_valid_q   <= 1'b0;
            error_pointer_valid_q   <= 1'b0;
            check_in_progress_q   <= 1'b0;
            ltype_q  <= 64'h0;
            laddr_q  <= 64'h0;
            state_q  <= ST_IDLE;
            p_restart_pointer_valid_q <= 1'b0;
            p_error_pointer_valid_q <= 1'b0;
        end else begin
            ctl_q    <= ctl_d;
            restart_pointer_valid_q   <= restart_pointer_valid_d;
            error_pointer_valid_q   <= error_pointer_valid_d;
            check_in_progress_q   <= check_in_progress_d;
            ltype_q  <= ltype_d;
            laddr_q  <= laddr_d;
            state_q  <= state_d;
            p_restart_pointer_valid_q <= p_restart_pointer_valid_d;
            p_error_pointer_valid_q <= p_error_pointer_valid_d;
        end
    end

    // exception pulse and shutdown level
    // both come straight from flip-flops; the exception is
    // decided from the same terms as the raise branch above
    always @(posedge clk) begin
        if (reset) begin
            hardware_error_exception <= 1'b0;
            shutdown                 <= 1'b0;
        end else begin
            // one-cycle abort-class exception
            hardware_error_exception <= (state_q == ST_RAISE)
                                     && !check_in_progress_q
                                     && !event_seen;
            // nested check: shutdown, no exception
            shutdown <= (state_d == ST_DEAD);
        end
    end

    // read data mux
    // unmapped targets read zero; the fault flag tells them apart
    reg [63:0] rd_word;       // selected register value
    always @* begin
        rd_word = 64'h0;
        case (rd_sel)
            SEL_CAP:    rd_word = cap_word;
            SEL_STATUS: begin
                // reserved bits above 2 read zero
                rd_word[`MCG_ST_RESTART_POINTER_VALID_BIT] = restart_pointer_valid_q;
                rd_word[`MCG_ST_ERROR_POINTER_VALID_BIT] = error_pointer_valid_q;
                rd_word[`MCG_ST_CHECK_IN_PROGRESS_BIT] = check_in_progress_q;
            end
            SEL_CTL:    rd_word = ctl_q;
            SEL_LTYPE:  rd_word = ltype_q;
            SEL_LADDR:  rd_word = laddr_q;
            default:    rd_word = 64'h0;
        endcase
    end

    // register access answers, one cycle after request
    // read data is forced to zero when no read is asked for,
    // so a stale word never stands on the data lines
    always @(posedge clk) begin
        if (reset) begin
            msr_rdata    <= 64'h0;
            msr_rd_valid <= 1'b0;
            msr_fault    <= 1'b0;
        end else begin
            msr_rd_valid <= msr_rd_en && (rd_sel != SEL_NONE);
            // model register access path
            msr_rdata    <= msr_rd_en ? rd_word : 64'h0;
            // unmapped read or write faults
            msr_fault    <= (msr_rd_en && (rd_sel == SEL_NONE))
                         || (msr_wr_en && (wr_sel == SEL_NONE));
            // writes to capability are dropped quietly
        end
    end

endmodule
`default_nettype wire

// ==== mcg_ctrl_asserts.sv ====
// port assertions for the machine-check global control block
`timescale 1ns/1ps
`default_nettype none
`include "mcg_defs.vh"
module mcg_ctrl_chk (
    input wire logic        clk,
    input wire logic        reset,
    input wire logic        msr_rd_en,
    input wire logic        msr_wr_en,
    input wire logic [31:0] msr_addr,
    input wire logic [63:0] msr_rdata,
    input wire logic        msr_rd_valid,
    input wire logic        msr_fault,
    input wire logic        unit_err,
    input wire logic        read_parity_err,
    input wire logic        bus_cycle_fail,
    input wire logic        hardware_error_exception,
    input wire logic        shutdown
);
    // one clock domain, quiet in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // capability word built from the constants
    localparam logic [63:0] CAP_V = {40'h0, `MCG_EXT_COUNT, 4'h0,
        `MCG_TES_PRESENT, 1'b0, `MCG_EXT_PRESENT, `MCG_CTL_PRESENT,
        `MCG_BANK_COUNT};
    wire logic any_err = unit_err | read_parity_err | bus_cycle_fail;
    wire logic any_acc = msr_rd_en | msr_wr_en; // any register request
    property p_cap_read;
        msr_rd_en && msr_addr == `MCG_ADDR_CAP |=>
            msr_rd_valid && msr_rdata == CAP_V;
    endproperty
    property p_st_resv;
        msr_rd_en && msr_addr == `MCG_ADDR_STATUS |=> msr_rdata[63:3] == '0;
    endproperty
    property p_exc_cause;
        $rose(hardware_error_exception) |-> $past(any_err, 2);
    endproperty
    property p_exc_pulse;
        hardware_error_exception |=> !hardware_error_exception;
    endproperty
    property p_shut_hold;
        shutdown |=> shutdown [*4];
    endproperty
    property p_shut_quiet;
        shutdown |-> !hardware_error_exception;
    endproperty
    property p_shut_cause;
        $rose(shutdown) |-> $past(any_err, 2);
    endproperty
    property p_rd_cause;
        msr_rd_valid |-> $past(msr_rd_en) && !msr_fault;
    endproperty
    property p_fault_cause;
        msr_fault |-> $past(any_acc);
    endproperty
    property p_rdata_idle;
        !$past(msr_rd_en) |-> msr_rdata == '0;
    endproperty
    a_cap_read: assert property (p_cap_read)
        else $error("cap read");
    a_st_resv: assert property (p_st_resv)
        else $error("resv bits");
    a_exc_cause: assert property (p_exc_cause)
        else $error("exc cause");
    a_exc_pulse: assert property (p_exc_pulse)
        else $error("exc width");
    a_shut_hold: assert property (p_shut_hold)
        else $error("shut hold");
    a_shut_quiet: assert property (p_shut_quiet)
        else $error("shut exc");
    a_shut_cause: assert property (p_shut_cause)
        else $error("shut cause");
    a_rd_cause: assert property (p_rd_cause)
        else $error("rd valid");
    a_fault_cause: assert property (p_fault_cause)
        else $error("fault");
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("rdata");
    // main scenarios reached
    c_exc: cover property (hardware_error_exception);
    c_shut: cover property ($rose(shutdown));
    c_fault: cover property (msr_fault);
endmodule
bind mcg_ctrl mcg_ctrl_chk mcg_ctrl_chk_i (.clk(clk), .reset(reset),
    .msr_rd_en(msr_rd_en), .msr_wr_en(msr_wr_en), .msr_addr(msr_addr),
    .msr_rdata(msr_rdata), .msr_rd_valid(msr_rd_valid),
    .msr_fault(msr_fault), .unit_err(unit_err),
    .read_parity_err(read_parity_err), .bus_cycle_fail(bus_cycle_fail),
    .hardware_error_exception(hardware_error_exception),
    .shutdown(shutdown));
`default_nettype wire

// ==== mcg_defs.vh ====
// constants of the machine-check global control block
`ifndef MCG_DEFS_VH
`define MCG_DEFS_VH

// register addresses seen by the register access port
`define MCG_ADDR_CAP      32'h0000_0179
`define MCG_ADDR_STATUS   32'h0000_0190
`define MCG_ADDR_CTL      32'h0000_0191
`define MCG_ADDR_LTYPE    32'h0000_0192
`define MCG_ADDR_LADDR    32'h0000_0193
`define MCG_ADDR_EXT_BASE 32'h0000_0180

// capability contents of this implementation
`define MCG_BANK_COUNT    8'h04
`define MCG_CTL_PRESENT   1'b1
`define MCG_EXT_PRESENT   1'b0
`define MCG_TES_PRESENT   1'b1
`define MCG_EXT_COUNT     8'h00

// capability field positions
`define MCG_CAP_CNT_LSB   0
`define MCG_CAP_CTL_BIT   8
`define MCG_CAP_EXT_BIT   9
`define MCG_CAP_TES_BIT   11
`define MCG_CAP_ECNT_LSB  16

// global status field positions
`define MCG_ST_RESTART_POINTER_VALID_BIT   0
`define MCG_ST_ERROR_POINTER_VALID_BIT   1
`define MCG_ST_CHECK_IN_PROGRESS_BIT   2

// legacy error type field positions
`define MCG_LT_PARITY_BIT 0
`define MCG_LT_BUS_BIT    1

// reset values and the all-ones enable pattern
`define MCG_CTL_RESET     64'h0000_0000_0000_0000
`define MCG_STATUS_RESET  3'h0
`define MCG_ENABLE_ALL    64'hFFFF_FFFF_FFFF_FFFF

`endif

// ==== testbench.sv ====
// self-checking bench for the machine-check global control block
`timescale 1ns/1ps
`default_nettype none
`include "mcg_defs.vh"
module testbench;
    logic        clk = 1'b0, reset = 1'b1;   // clock and reset
    logic        rd = 1'b0, wr = 1'b0;       // register requests
    logic [31:0] adr = '0;                   // register address
    logic [63:0] wd = '0, ea = '0;           // write data, error address
    logic        ue = 1'b0, uok = 1'b0, uip = 1'b0; // unit error
    logic        pe = 1'b0, bf = 1'b0;       // legacy errors
    logic [63:0] rdat;                       // read data
    logic        rval, flt, exc, shut;       // design answers
    logic [31:0] lf = 32'h0000_0043;         // random state
    int          bad_count = 0, samples_checked = 0;
    localparam logic [63:0] CAPV = 64'h0000_0000_0000_0904;
    mcg_ctrl mcg_ctrl_i (.clk(clk), .reset(reset), .msr_rd_en(rd),
        .msr_wr_en(wr), .msr_addr(adr), .msr_wdata(wd), .msr_rdata(rdat),
        .msr_rd_valid(rval), .msr_fault(flt), .unit_err(ue),
        .unit_err_restart_ok(uok), .unit_err_ip_assoc(uip),
        .read_parity_err(pe), .bus_cycle_fail(bf), .err_address(ea),
        .hardware_error_exception(exc), .shutdown(shut));
    // next random word
    function logic [31:0] nx(input logic [31:0] s);
        return {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
    endfunction
    // status after a raise with given restart and pointer bits
    function logic [63:0] st(input logic o, input logic i);
        return {61'h0, 1'b1, i, o};
    endfunction
    // compare and count
    task chk(input string n, input logic [63:0] s, input logic [63:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("BAD %s exp %h got %h", n, e, s);
        end
    endtask
    // one access; answers sampled in the cycle after
    task acc(input logic r, input logic w, input logic [31:0] a,
        input logic [63:0] d, input logic ev, input logic ef,
        input logic [63:0] ed);
        @(posedge clk);
        rd <= r;
        wr <= w;
        adr <= a;
        wd <= d;
        @(posedge clk);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
        chk("rdata", rdat, ed);
        chk("rd_valid", 64'(rval), 64'(ev));
        chk("fault", 64'(flt), 64'(ef));
    endtask
    // one-cycle error pulse; exception expected two edges later
    task err(input logic [2:0] k, input logic o, input logic i,
        input logic ex, input logic sh);
        @(posedge clk);
        {bf, pe, ue} <= k;
        uok <= o;
        uip <= i;
        ea <= {lf, ~lf};
        @(posedge clk);
        {bf, pe, ue} <= 3'h0;
        #1;
        chk("exc early", 64'(exc), 64'h0);
        @(posedge clk);
        #1;
        chk("exc", 64'(exc), 64'(ex));
        chk("shutdown", 64'(shut), 64'(sh));
        @(posedge clk);
        #1;
        chk("exc late", 64'(exc), 64'h0);
    endtask
    // verdict and end of run
    task conclude;
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // 50 MHz clock
    initial begin
        forever #10 clk = ~clk;
    end
    // hang guard
    initial begin
        repeat (2000) @(posedge clk);
        bad_count++;
        conclude();
    end
    // main sequence
    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        acc('1, '0, `MCG_ADDR_CAP, '0, '1, '0, CAPV);
        acc('1, '0, `MCG_ADDR_STATUS, '0, '1, '0, '0);
        lf = nx(lf);
        acc('0, '1, `MCG_ADDR_CAP, {lf, lf}, '0, '0, '0);
        acc('1, '0, `MCG_ADDR_CAP, '0, '1, '0, CAPV);
        acc('1, '0, {20'h0, lf[11:0] | 12'h800}, '0, '0, '1, '0);
        err(3'h1, '1, '1, '0, '0);
        acc('0, '1, `MCG_ADDR_CTL, {32'h0, lf}, '0, '0, '0);
        err(3'h4, '0, '0, '0, '0);
        acc('0, '1, `MCG_ADDR_CTL, `MCG_ENABLE_ALL, '0, '0, '0);
        acc('1, '0, `MCG_ADDR_CTL, '0, '1, '0, `MCG_ENABLE_ALL);
        for (int n = 0; n < 4; n++) begin
            lf = nx(lf);
            err(3'h1, n[0], n[1], '1, '0);
            acc('1, '0, `MCG_ADDR_STATUS, '0, '1, '0, st(n[0], n[1]));
            acc('0, '1, `MCG_ADDR_STATUS, '0, '0, '0, '0);
        end
        err(3'h2, '1, '1, '1, '0);
        acc('1, '0, `MCG_ADDR_LTYPE, '0, '1, '0, 64'h1);
        acc('1, '0, `MCG_ADDR_LADDR, '0, '1, '0, {lf, ~lf});
        acc('1, '0, `MCG_ADDR_STATUS, '0, '1, '0, st('0, '0));
        acc('0, '1, `MCG_ADDR_STATUS, '0, '0, '0, '0);
        lf = nx(lf);
        err(3'h4, '0, '0, '1, '0);
        acc('1, '0, `MCG_ADDR_LADDR, '0, '1, '0, {lf, ~lf});
        acc('1, '0, `MCG_ADDR_LTYPE, '0, '1, '0, 64'h2);
        acc('0, '1, `MCG_ADDR_STATUS, `MCG_ENABLE_ALL, '0, '0, '0);
        acc('1, '0, `MCG_ADDR_STATUS, '0, '1, '0, 64'h7);
        err(3'h1, '1, '0, '0, '1);
        acc('1, '0, `MCG_ADDR_STATUS, '0, '1, '0, 64'h7);
        conclude();
    end
endmodule
`default_nettype wire
